// *** verilog/rom_readout_ctrl.sv ***
// readout order, merge, dark-row/column framing and sleep/wake sequencer, plus its FIFO
// assumes a pixel array answering a read address combinationally on the same clock,
// and a register port from the serial control logic on the same clock
`include "rom_defs.svh"

module rom_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rom_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign do_wr       = i_in_valid && o_in_ready;
  assign do_rd       = o_out_valid && i_out_ready;

  // storage has no reset: only entries behind the count are ever read
  always_ff @(posedge i_clk) begin
    if (do_wr) mem[wr_ptr] <= i_in_data;
  end

  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : rom_fifo

module rom_readout_ctrl #(
  parameter int      PIX_W        = 10,
  parameter int      ADDR_W       = 10,
  parameter int      FIFO_DEPTH   = 16,
  parameter longint  SLEEP_CYCLES = `ROM_SLEEP_CYCLES
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  // register port from the serial control logic
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [15:0]       i_reg_wdata,
  output logic [15:0]            o_reg_rdata,
  // window settings held elsewhere
  input  wire logic [ADDR_W-1:0] i_row_start,
  input  wire logic [ADDR_W-1:0] i_win_rows,
  input  wire logic [ADDR_W-1:0] i_col_start,
  input  wire logic [ADDR_W-1:0] i_win_cols,
  // pixel array read port
  output logic                   o_rd_dark,
  output logic [ADDR_W-1:0]      o_rd_row,
  output logic [ADDR_W-1:0]      o_rd_col,
  input  wire logic [PIX_W-1:0]  i_rd_data,
  // pixel stream to the host
  output logic                   o_pix_strobe,
  output logic                   o_frame_valid,
  output logic                   o_line_valid,
  output logic [PIX_W-1:0]       o_pix_data,
  output logic                   o_asleep
);
  // blanking must divide by every merge factor, else the frame rate would follow the merge
  if (PIX_W < 1 || PIX_W > 16 || ADDR_W < 5 || ADDR_W > 12 || SLEEP_CYCLES < 2 ||
      (`ROM_HBLANK_PCLK % 4) != 0 || (`ROM_HBLANK_PCLK / 4) <= `ROM_DARK_COLS ||
      (`ROM_VBLANK_WORDS % 4) != 0) begin : g_bad_param
    $error("rom_readout_ctrl parameters out of range");
  end
  localparam int WW = PIX_W + 2;
  localparam logic [11:0] HB_FULL  = 12'(`ROM_HBLANK_PCLK);
  localparam logic [11:0] DK_COLS  = 12'(`ROM_DARK_COLS);
  localparam logic [11:0] VB_WORDS = 12'(`ROM_VBLANK_WORDS);
  localparam logic [ADDR_W:0] DK_ROWS = (ADDR_W+1)'(`ROM_DARK_ROWS);

  // software-visible registers
  logic [15:0] read_options;
  logic [15:0] sleep_wake_control;
  logic [15:0] wake_frame_count;
  // active copies taken at frame start
  logic [1:0]        bin_act;
  logic              rflip_act;
  logic              cflip_act;
  logic              drow_act;
  logic              dcol_act;
  logic              sleep_act;
  logic [ADDR_W-1:0] rstart_act;
  logic [ADDR_W-1:0] rows_act;
  logic [ADDR_W-1:0] cstart_act;
  logic [ADDR_W-1:0] cols_act;
  // sequencer state
  rom_pkg::rom_state_type state;
  logic [11:0]       cnt;
  logic [ADDR_W:0]   row;
  logic [1:0]        sub;
  logic [PIX_W+1:0]  acc;
  logic [15:0]       frames_done;
  logic [63:0]       sleep_cnt;
  logic [1:0]        div_cnt;
  // stream path
  logic              push;
  logic              step;
  logic              fifo_ready;
  logic              fifo_valid;
  logic [WW-1:0]     fifo_out;
  logic [WW-1:0]     push_word;
  logic              row_shown;
  logic [ADDR_W:0]   act_row;
  logic [PIX_W+1:0]  sum;
  logic [1:0]        last_sub;
  logic [PIX_W-1:0]  merged;
  logic [ADDR_W-1:0] next_col;
  logic [11:0]       hb_words;
  logic [11:0]       vb_words;

  // register writes; the merge field refuses code 3 so the sequencer never sees it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      read_options       <= `ROM_RST_READ_OPTIONS;
      sleep_wake_control <= `ROM_RST_SLEEP_WAKE;
      wake_frame_count   <= `ROM_RST_WAKE_FRAMES;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `ROM_OFS_READ_OPTIONS: begin
          read_options[15:4] <= i_reg_wdata[15:4];
          read_options[1:0]  <= i_reg_wdata[1:0];
          if (i_reg_wdata[`ROM_COLBIN_LSB+:2] != 2'h3)
            read_options[`ROM_COLBIN_LSB+:2] <= i_reg_wdata[`ROM_COLBIN_LSB+:2];
        end
        `ROM_OFS_SLEEP_WAKE:  sleep_wake_control <= {15'h0000, i_reg_wdata[`ROM_SLEEP_EN_BIT]};
        `ROM_OFS_WAKE_FRAMES: wake_frame_count   <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // register reads, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `ROM_OFS_READ_OPTIONS: o_reg_rdata <= read_options;
        `ROM_OFS_SLEEP_WAKE: begin
          o_reg_rdata                 <= sleep_wake_control;
          o_reg_rdata[`ROM_ASLEEP_BIT] <= (state == rom_pkg::ST_SLEEP);
        end
        `ROM_OFS_WAKE_FRAMES:  o_reg_rdata <= wake_frame_count;
        default:               o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  // shadow copies move only at the internal frame start
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bin_act    <= 2'h0;
      rflip_act  <= 1'b0;
      cflip_act  <= 1'b0;
      drow_act   <= 1'b0;
      dcol_act   <= 1'b0;
      sleep_act  <= 1'b0;
      rstart_act <= '0;
      rows_act   <= '0;
      cstart_act <= '0;
      cols_act   <= '0;
    end else if (state == rom_pkg::ST_FRAME) begin
      bin_act    <= read_options[`ROM_COLBIN_LSB+:2];
      rflip_act  <= read_options[`ROM_ROWFLIP_BIT];
      cflip_act  <= read_options[`ROM_COLFLIP_BIT];
      drow_act   <= read_options[`ROM_DARKROW_BIT];
      dcol_act   <= read_options[`ROM_DARKCOL_BIT];
      sleep_act  <= sleep_wake_control[`ROM_SLEEP_EN_BIT];
      rstart_act <= i_row_start;
      rows_act   <= i_win_rows;
      cstart_act <= i_col_start;
      cols_act   <= i_win_cols;
    end
  end

  // read addressing: dark rows come first, then the window in the chosen order
  assign act_row   = row - DK_ROWS;
  assign o_rd_dark = (row < DK_ROWS) || (state == rom_pkg::ST_DARKCOL);
  always_comb begin
    if (row < DK_ROWS)
      o_rd_row = row[ADDR_W-1:0];
    else if (rflip_act)
      o_rd_row = rstart_act + rows_act - act_row[ADDR_W-1:0];
    else
      o_rd_row = rstart_act + act_row[ADDR_W-1:0];
  end
  assign next_col = cnt[ADDR_W-1:0];
  always_comb begin
    if (state == rom_pkg::ST_DARKCOL)
      o_rd_col = next_col;
    else if (cflip_act)
      o_rd_col = cstart_act + cols_act - next_col;
    else
      o_rd_col = cstart_act + next_col;
  end

  // merge: average of 1, 2 or 4 adjacent columns per output pixel
  assign last_sub = (bin_act == 2'h2) ? 2'h3 : ((bin_act == 2'h1) ? 2'h1 : 2'h0);
  assign sum      = acc + (PIX_W+2)'(i_rd_data);
  assign merged   = PIX_W'(sum >> bin_act);

  // blanking in pixel words shrinks with the merge so the master-clock frame period holds
  assign hb_words = (HB_FULL >> bin_act) - (dcol_act ? DK_COLS : 12'h000);
  assign vb_words = VB_WORDS >> bin_act;

  // dark rows still take their time slot, shown only when enabled
  assign row_shown = (row >= DK_ROWS) || drow_act;
  always_comb begin
    push      = 1'b0;
    push_word = '0;
    case (state)
      // frame start sends one blank word so full-rate streams never see a bubble
      rom_pkg::ST_FRAME: begin
        push      = 1'b1;
        push_word = '0;
      end
      rom_pkg::ST_HBLANK: begin
        push      = 1'b1;
        push_word = {row_shown, 1'b0, {PIX_W{1'b0}}};
      end
      rom_pkg::ST_DARKCOL: begin
        push      = 1'b1;
        push_word = {row_shown, row_shown, i_rd_data};
      end
      rom_pkg::ST_ACTIVE: begin
        push      = (sub == last_sub);
        push_word = {row_shown, row_shown, merged};
      end
      rom_pkg::ST_VBLANK: begin
        push      = 1'b1;
        push_word = '0;
      end
      default: ;
    endcase
  end
  // back-pressure: the sequencer freezes on any push the FIFO cannot take
  assign step = !push || fifo_ready;

  // frame sequencer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state       <= rom_pkg::ST_FRAME;
      cnt         <= 12'h000;
      row         <= '0;
      sub         <= 2'h0;
      acc         <= '0;
      frames_done <= 16'h0000;
      sleep_cnt   <= 64'h0;
    end else if (step) begin
      case (state)
        rom_pkg::ST_SLEEP: begin
          sleep_cnt <= sleep_cnt + 64'h1;
          if (!sleep_wake_control[`ROM_SLEEP_EN_BIT]) begin
            state <= rom_pkg::ST_FRAME;
          end else if (sleep_cnt >= 64'(SLEEP_CYCLES) - 64'h1) begin
            state <= rom_pkg::ST_FRAME;
          end
        end
        rom_pkg::ST_FRAME: begin
          // internal frame start, always ahead of the dark rows
          row   <= '0;
          cnt   <= 12'h000;
          state <= rom_pkg::ST_HBLANK;
        end
        rom_pkg::ST_HBLANK: begin
          cnt <= cnt + 12'h001;
          if (cnt >= hb_words - 12'h001) begin
            cnt   <= 12'h000;
            state <= dcol_act ? rom_pkg::ST_DARKCOL : rom_pkg::ST_ACTIVE;
          end
        end
        rom_pkg::ST_DARKCOL: begin
          cnt <= cnt + 12'h001;
          if (cnt == DK_COLS - 12'h001) begin
            cnt   <= 12'h000;
            state <= rom_pkg::ST_ACTIVE;
          end
        end
        rom_pkg::ST_ACTIVE: begin
          cnt <= cnt + 12'h001;
          sub <= (sub == last_sub) ? 2'h0 : sub + 2'h1;
          acc <= (sub == last_sub) ? '0 : sum;
          if (cnt >= 12'(cols_act) - 12'h001) begin
            cnt <= 12'h000;
            sub <= 2'h0;
            acc <= '0;
            row <= row + 1'b1;
            if (row >= DK_ROWS + (ADDR_W+1)'(rows_act) - 1'b1)
              state <= rom_pkg::ST_VBLANK;
            else
              state <= rom_pkg::ST_HBLANK;
          end
        end
        rom_pkg::ST_VBLANK: begin
          cnt <= cnt + 12'h001;
          // the last blank word of the frame is the one sent at frame start
          if (cnt >= vb_words - 12'h002) begin
            cnt <= 12'h000;
            if (sleep_act && frames_done + 16'h0001 >= wake_frame_count) begin
              frames_done <= 16'h0000;
              sleep_cnt   <= 64'h0;
              state       <= rom_pkg::ST_SLEEP;
            end else begin
              frames_done <= sleep_act ? frames_done + 16'h0001 : 16'h0000;
              state       <= rom_pkg::ST_FRAME;
            end
          end
        end
        default: state <= rom_pkg::ST_FRAME;
      endcase
    end
  end

  rom_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (push),
    .i_in_data   (push_word),
    .o_in_ready  (fifo_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_out),
    .i_out_ready (o_pix_strobe)
  );

  // pixel clock divider: one strobe per 1, 2 or 4 master clocks
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) div_cnt <= 2'h0;
    else if (div_cnt >= last_sub) div_cnt <= 2'h0;
    else div_cnt <= div_cnt + 2'h1;
  end
  assign o_pix_strobe = (div_cnt == 2'h0);

  // output stage; an underrun shows as blanking rather than stale data
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_frame_valid <= 1'b0;
      o_line_valid  <= 1'b0;
      o_pix_data    <= '0;
    end else if (o_pix_strobe) begin
      o_frame_valid <= fifo_valid && fifo_out[WW-1];
      o_line_valid  <= fifo_valid && fifo_out[WW-2];
      o_pix_data    <= fifo_valid ? fifo_out[PIX_W-1:0] : '0;
    end
  end

  assign o_asleep = (state == rom_pkg::ST_SLEEP);
endmodule : rom_readout_ctrl

// *** verilog/rom_defs.svh ***
// register offsets, field positions, reset values and timing counts of the readout
// sequencer; included by the design file, the monitor and the bench
`ifndef ROM_DEFS_SVH
`define ROM_DEFS_SVH
// register offsets on the internal register port
`define ROM_OFS_READ_OPTIONS  8'h0d
`define ROM_OFS_SLEEP_WAKE    8'h0e
`define ROM_OFS_WAKE_FRAMES   8'hc0
// readout_options fields
`define ROM_COLBIN_LSB        2
`define ROM_ROWFLIP_BIT       4
`define ROM_COLFLIP_BIT       5
`define ROM_DARKROW_BIT       6
`define ROM_DARKCOL_BIT       7
// sleep_wake_control fields
`define ROM_SLEEP_EN_BIT      0
`define ROM_ASLEEP_BIT        1
// reset values
`define ROM_RST_READ_OPTIONS  16'h0300
`define ROM_RST_SLEEP_WAKE    16'h0000
`define ROM_RST_WAKE_FRAMES   16'h0001
// timing
`define ROM_DARK_COLS         18
`define ROM_DARK_ROWS         4
`define ROM_HBLANK_PCLK       96 // multiple of four: every merge factor keeps a whole line period
`define ROM_VBLANK_WORDS      2048
`define ROM_SLEEP_S           300
`define ROM_CLK_HZ            100000000
`define ROM_SLEEP_CYCLES      (64'd`ROM_SLEEP_S * 64'd`ROM_CLK_HZ)
`endif

// *** verilog/rom_pkg.sv ***
// types shared by the readout sequencer
// assumes nothing beyond a SystemVerilog compiler
package rom_pkg;
  // producer sequence of one frame
  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_FRAME,
    ST_HBLANK,
    ST_DARKCOL,
    ST_ACTIVE,
    ST_VBLANK
  } rom_state_type;
endpackage : rom_pkg

// *** tb/rom_readout_monitor.sv ***
// checker of the readout sequencer ports: register port, pixel framing, sleep
// assumes one clock and the active-low asynchronous reset of the top module
`include "rom_defs.svh"
module rom_readout_monitor #(
  parameter longint SLEEP_CYCLES = 200
) (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // register port
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  // pixel stream
  input wire logic        o_pix_strobe,
  input wire logic        o_frame_valid,
  input wire logic        o_line_valid,
  input wire logic        o_asleep
);
  timeunit 1ns;
  timeprecision 100ps;
  longint sleep_cnt;
  // sleep is far too long for a repetition, so it is counted
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) sleep_cnt <= 0;
    else sleep_cnt <= o_asleep ? sleep_cnt + 1 : 0;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // a write of the frame count followed at once by its read
  sequence frames_wr;
    i_reg_wr && i_reg_addr == `ROM_OFS_WAKE_FRAMES;
  endsequence
  sequence frames_rd;
    i_reg_rd && !i_reg_wr && i_reg_addr == `ROM_OFS_WAKE_FRAMES;
  endsequence
  chk_merge_code: assert property (
    i_reg_rd && i_reg_addr == `ROM_OFS_READ_OPTIONS |=> o_reg_rdata[3:2] != 2'b11)
    else $error("merge field reads three");
  chk_strobe_gap: assert property (
    o_pix_strobe && !o_asleep |-> ##[1:4] (o_pix_strobe || o_asleep))
    else $error("pixel clock slower than a quarter");
  chk_out_hold: assert property (
    !$past(o_pix_strobe) |-> $stable(o_frame_valid) && $stable(o_line_valid))
    else $error("stream changed between pixel clocks");
  chk_line_in_frame: assert property (
    o_line_valid |-> o_frame_valid) else $error("line valid outside frame");
  chk_sleep_quiet: assert property (
    o_asleep |-> !o_line_valid) else $error("pixels while asleep");
  chk_sleep_len: assert property (
    sleep_cnt <= SLEEP_CYCLES) else $error("sleep too long");
  chk_sleep_status: assert property (
    i_reg_rd && i_reg_addr == `ROM_OFS_SLEEP_WAKE && o_asleep
    |=> o_reg_rdata[`ROM_ASLEEP_BIT]) else $error("asleep status low");
  chk_count_back: assert property (
    frames_wr ##1 frames_rd |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("frame count read back wrong");
  chk_sleep_exit: assert property (
    o_asleep && i_reg_wr && i_reg_addr == `ROM_OFS_SLEEP_WAKE && !i_reg_wdata[0]
    |-> ##2 !o_asleep) else $error("still asleep after clear");
endmodule : rom_readout_monitor

bind rom_readout_ctrl rom_readout_monitor #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_mon (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_pix_strobe(o_pix_strobe), .o_frame_valid(o_frame_valid),
  .o_line_valid(o_line_valid), .o_asleep(o_asleep));

// *** tb/rom_host_model.sv ***
// host capture model: one sample of the stream per pixel clock
// assumes the stream settles the cycle after a strobe; no back-pressure
module rom_host_model (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  // pixel stream
  input wire logic       i_pix_strobe,
  input wire logic       i_frame_valid,
  input wire logic       i_line_valid,
  input wire logic [9:0] i_pix_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       take = 1'b0;
  logic       fv_q = 1'b0;
  logic       lv_q = 1'b0;
  int         lines, len, per, words, frames, clks, frame_clk, gap, since;
  logic [9:0] pix_q[$];
  logic [9:0] frame_q[$];
  // clocks between pixel clocks
  always @(posedge i_clk) begin
    since <= i_pix_strobe ? 1 : since + 1;
    if (i_pix_strobe) gap <= since;
  end
  // framing counters; a frame is published only once frame valid falls
  always @(posedge i_clk) begin
    take <= i_pix_strobe && i_rst_b;
    clks <= clks + 1;
    if (take) begin
      words++;
      if (i_frame_valid && !fv_q) begin
        frame_clk <= clks;
        clks <= 1;
        lines = 0;
        pix_q = {};
      end
      if (!i_frame_valid && fv_q) begin
        frame_q = pix_q;
        frames <= frames + 1;
      end
      if (i_line_valid && !lv_q) begin
        lines++;
        per = words;
        words = 0;
        len = 0;
      end
      if (i_line_valid) begin
        len++;
        pix_q.push_back(i_pix_data);
      end
      fv_q = i_frame_valid;
      lv_q = i_line_valid;
    end
  end
endmodule : rom_host_model

// *** tb/test_readout_order_and_monitor_ctrl.sv ***
// self-checking bench of the readout sequencer with a host capture model
// assumes rom_defs.svh on the include path; the array below answers at once
`include "rom_defs.svh"
module test_readout_order_and_monitor_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ROWS = 4;
  localparam int COLS = 8;
  localparam int R0   = 5;
  localparam int C0   = 3;
  localparam int SLP  = 200;
  logic        i_clk, i_rst_b, i_reg_wr, i_reg_rd;
  logic [7:0]  i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, opt, got;
  logic        o_rd_dark, o_pix_strobe, o_frame_valid, o_line_valid, o_asleep;
  logic [9:0]  o_rd_row, o_rd_col, o_pix_data, i_rd_data;
  int          miscompares, n_compared, t, n, m, base, slp, s0;
  logic [15:0] cfg[3] = '{16'h0300, 16'h0354, 16'h03a8};
  // dark cells read 1, light cells their own address, so order is visible
  assign i_rd_data = o_rd_dark ? 10'h001 : {o_rd_row[4:0], o_rd_col[4:0]};
  rom_readout_ctrl #(.SLEEP_CYCLES(SLP)) u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_row_start(10'(R0)), .i_win_rows(10'(ROWS)), .i_col_start(10'(C0)),
    .i_win_cols(10'(COLS)), .o_rd_dark(o_rd_dark), .o_rd_row(o_rd_row),
    .o_rd_col(o_rd_col), .i_rd_data(i_rd_data), .o_pix_strobe(o_pix_strobe),
    .o_frame_valid(o_frame_valid), .o_line_valid(o_line_valid),
    .o_pix_data(o_pix_data), .o_asleep(o_asleep));
  rom_host_model u_host (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_pix_strobe(o_pix_strobe),
    .i_frame_valid(o_frame_valid), .i_line_valid(o_line_valid), .i_pix_data(o_pix_data));
  // clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // sleeping clocks; non-blocking so readers see the count before this edge
  always @(posedge i_clk) if (o_asleep) slp <= slp + 1;
  task automatic test_done;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] a, input logic [31:0] e);
    n_compared++;
    if (a !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : wr
  // read data stands until the next read, so the second edge sees it settled
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_clk);
    got = o_reg_rdata;
    check(got, e);
  endtask : rdc
  task automatic wait_frames(input int k);
    n = u_host.frames + k;
    for (t = 0; t < 80000 && u_host.frames < n; t++) @(posedge i_clk);
    if (u_host.frames < n) begin
      miscompares++;
      test_done();
    end
  endtask : wait_frames
  task automatic wait_sleep(input logic lvl);
    for (t = 0; t < 60000 && o_asleep !== lvl; t++) @(posedge i_clk);
    if (o_asleep !== lvl) begin
      miscompares++;
      test_done();
    end
  endtask : wait_sleep
  // light pixel: read row, then the mean of the merged columns in read order
  function automatic logic [9:0] exp_pix(input logic rf, input logic cf, input int r,
                                         input int j);
    int row;
    int sum;
    row = rf ? R0 + ROWS - r : R0 + r;
    sum = 0;
    for (int i = 0; i < (1 << m); i++) begin
      sum += cf ? C0 + COLS - (j << m) - i : C0 + (j << m) + i;
    end
    return {row[4:0], 5'(sum >> m)};
  endfunction : exp_pix
  // three frames so the measured one and the one before share the settings
  task automatic run_cfg(input logic [15:0] o);
    wr(`ROM_OFS_READ_OPTIONS, o);
    rdc(`ROM_OFS_READ_OPTIONS, o);
    wait_frames(3);
    m = int'(o[3:2]);
    base = (o[6] ? 4 : 0) * u_host.len + (o[7] ? 18 : 0);
    check(u_host.lines, ROWS + (o[6] ? 4 : 0));
    check(u_host.len, (COLS >> m) + (o[7] ? 18 : 0));
    check(u_host.per, (`ROM_HBLANK_PCLK >> m) + (COLS >> m));
    check(u_host.gap, 1 << m);
    check(u_host.frame_clk, 8 * (`ROM_HBLANK_PCLK + COLS) + `ROM_VBLANK_WORDS);
    check(u_host.frame_q[0], (o[6] | o[7]) ? 10'h001 : exp_pix(o[4], o[5], 0, 0));
    for (int r = 0; r < ROWS; r++) begin
      for (int j = 0; j < (COLS >> m); j++) begin
        check(u_host.frame_q[base + r * u_host.len + j], exp_pix(o[4], o[5], r, j));
      end
    end
  endtask : run_cfg
  // main sequence
  initial begin
    i_rst_b     = 1'b0;
    i_reg_wr    = 1'b0;
    i_reg_rd    = 1'b0;
    i_reg_addr  = 8'h00;
    i_reg_wdata = 16'h0000;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    void'($urandom(32'h29ac));
    rdc(`ROM_OFS_READ_OPTIONS, `ROM_RST_READ_OPTIONS);
    rdc(`ROM_OFS_SLEEP_WAKE, 16'h0000);
    rdc(8'h55, 16'h0000);
    wr(`ROM_OFS_READ_OPTIONS, 16'h03fc);
    rdc(`ROM_OFS_READ_OPTIONS, 16'h03f0);
    // corner settings first, then random legal ones
    for (int k = 0; k < 5; k++) begin
      opt = (k < 3) ? cfg[k] : 16'h0300 | 16'($urandom_range(0, 2) << 2);
      if (k >= 3) opt = opt | (16'($urandom) & 16'h00f0);
      run_cfg(opt);
    end
    // sleep and wake cycle, then leave it during a sleep
    rdc(`ROM_OFS_WAKE_FRAMES, `ROM_RST_WAKE_FRAMES);
    wr(`ROM_OFS_WAKE_FRAMES, 16'h0002);
    rdc(`ROM_OFS_WAKE_FRAMES, 16'h0002);
    wr(`ROM_OFS_SLEEP_WAKE, 16'h0001);
    rdc(`ROM_OFS_SLEEP_WAKE, 16'h0001);
    wait_sleep(1'b1);
    s0 = slp;
    rdc(`ROM_OFS_SLEEP_WAKE, 16'h0003);
    wait_sleep(1'b0);
    check(slp - s0, SLP);
    s0 = u_host.frames;
    wait_sleep(1'b1);
    check(u_host.frames - s0, 2);
    wr(`ROM_OFS_SLEEP_WAKE, 16'h0000);
    // the sequencer sees the cleared enable one edge after the write lands
    @(posedge i_clk);
    rdc(`ROM_OFS_SLEEP_WAKE, 16'h0000);
    s0 = slp;
    wait_frames(2);
    check(slp - s0, 0);
    test_done();
  end
endmodule : test_readout_order_and_monitor_ctrl
